// ==== rtl/reset_mode_pkg.sv ====
// Package: reset sequencer constants, mode configuration struct, state record
package reset_mode_pkg;

  localparam int          DATA_W          = 16;
  localparam int          FIRST_CYCLE_DLY = 10;
  localparam logic [3:0]  FIRST_CYCLE_CNT = 4'(FIRST_CYCLE_DLY);
  localparam int          BREAKPOINT_PIN_LOW_MIN    = 2;
  localparam logic [1:0]  BREAKPOINT_PIN_LOW_CNT    = 2'(BREAKPOINT_PIN_LOW_MIN);
  localparam int          MON_TIMEOUT     = 64;
  localparam logic [6:0]  MON_TIMEOUT_CNT = 7'(MON_TIMEOUT);
  localparam int          RST_HOLD        = 16;
  localparam logic [4:0]  RST_HOLD_CNT    = 5'(RST_HOLD);

  // Bit positions of mode select data lines
  localparam int          BOOT_SIZE_BIT   = 0;
  localparam int          ARB_BIT         = 1;
  localparam int          FC_BIT          = 2;
  localparam int          ADDR_LO_BIT     = 3;
  localparam int          ADDR_HI_BIT     = 7;
  localparam int          PORT_E_BIT      = 8;
  localparam int          PORT_F_BIT      = 9;
  localparam int          RSVD_BIT        = 11;

  typedef enum logic [1:0] {
    ST_RESET,
    ST_RELEASE,
    ST_RUN
  } seq_e;

  typedef struct packed {
    logic       boot_16bit;
    logic       cs_to_arbitration;
    logic       cs_to_function_code;
    logic [4:0] cs_to_address;
    logic       general_port_e;
    logic       general_port_f;
    logic       reserved_mode;
    logic       clock_from_synthesizer_oscillator;
    logic       background_enable;
  } mode_cfg_s;

  localparam mode_cfg_s MODE_CFG_RST = '{
    boot_16bit: 1'b1, cs_to_arbitration: 1'b0, cs_to_function_code: 1'b0,
    cs_to_address: 5'h00, general_port_e: 1'b0, general_port_f: 1'b0,
    reserved_mode: 1'b0, clock_from_synthesizer_oscillator: 1'b1,
    background_enable: 1'b0};

  typedef struct packed {
    logic [2:0] pin_sync;
    logic [2:0] clock_source_select_pin_sync;
    logic [2:0] breakpoint_pin_sync;
    logic       pin_req;
    logic       clock_source_select_pin_lvl;
    logic       breakpoint_pin_lvl;
    logic [1:0] breakpoint_pin_low_cnt;
    logic       async_hold;
    logic       sync_hold;
    logic       clk_rst_hold;
    logic [4:0] hold_cnt;
    logic [6:0] mon_cnt;
    logic       mon_abort;
    logic [3:0] first_cnt;
    logic       first_cycle_go;
    logic       pin_reset_drive;
    logic       clock_unit_reset;
    logic       global_logic_reset;
    logic       boot_chip_select;
    mode_cfg_s  cfg;
    seq_e       seq;
  } seq_state_s;

endpackage

// ==== rtl/reset_control_mode_latch.sv ====
// Reset source control, reset output sequencing and reset-time mode latch
`timescale 1ns/100ps

//Contract
// - Identify cause, synchronize, drive three resets
// - Resets clocked; asynchronous ones act immediately
// - Synchronous reset waits for bus cycle end
// - Monitor forced on, terminates stuck cycle
// - Source timing classes; test spares clock reset
// - In-progress internal write completes cleanly
// - Data lines sampled; high default, low alternate
// - Data 0 selects boot port size
// - Data 1, 2 convert chip-select groups
// - Data 7..3 convert chip-selects to address
// - Data 8 low selects port E
// - Data 9 low selects port F
// - Clock mode pin picks clock source
// - Breakpoint pin low enables background mode
// - First bus cycle ten clocks after release
// - Boot chip-select active, vectors from zero
// - Breakpoint low two synchronized clocks needed
module reset_control_mode_latch
  import reset_mode_pkg::*;
#(
  parameter int DW = DATA_W
) (
  input  wire logic          sys_clk,
  input  wire logic          rstn,
  input  wire logic          reset_pin_n,
  input  wire logic          power_up_reset,
  input  wire logic          watchdog_timeout,
  input  wire logic          internal_halt,
  input  wire logic          clock_reference_lost,
  input  wire logic          test_mode_reset,
  input  wire logic          bus_cycle_active,
  input  wire logic          bus_cycle_done,
  input  wire logic [DW-1:0] data_bus_in,
  input  wire logic          clock_source_select_pin,
  input  wire logic          breakpoint_pin,
  output logic               pin_reset_drive,
  output logic               clock_unit_reset,
  output logic               global_logic_reset,
  output logic               bus_monitor_abort,
  output logic               first_bus_cycle_start,
  output logic               boot_chip_select,
  output mode_cfg_s          mode_cfg
);

  logic [1:0] rst_sync_q;
  logic       rst_n;

  // Reset release through two flops; assertion stays asynchronous
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rst_sync_q <= 2'b00;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  function automatic logic agreed(input logic [2:0] s, input logic prev);
    agreed = (s[2] == s[1]) ? s[1] : prev;
  endfunction

  localparam seq_state_s STATE_RST = '{
    pin_sync: 3'h7, clock_source_select_pin_sync: 3'h7, breakpoint_pin_sync: 3'h7,
    pin_req: 1'b0, clock_source_select_pin_lvl: 1'b1, breakpoint_pin_lvl: 1'b1,
    breakpoint_pin_low_cnt: 2'h0, async_hold: 1'b1, sync_hold: 1'b0,
    clk_rst_hold: 1'b1, hold_cnt: 5'h00, mon_cnt: 7'h00,
    mon_abort: 1'b0, first_cnt: 4'h0, first_cycle_go: 1'b0,
    pin_reset_drive: 1'b1, clock_unit_reset: 1'b1,
    global_logic_reset: 1'b1, boot_chip_select: 1'b0,
    cfg: MODE_CFG_RST, seq: ST_RESET};

  seq_state_s s_q;
  seq_state_s s_d;
  logic       async_src;
  logic       sync_src;
  logic       sync_clk_src;
  logic       cycle_end;

  always_comb begin
    s_d = s_q;
    s_d.pin_sync    = {s_q.pin_sync[1:0], ~reset_pin_n};
    s_d.clock_source_select_pin_sync = {s_q.clock_source_select_pin_sync[1:0], clock_source_select_pin};
    s_d.breakpoint_pin_sync   = {s_q.breakpoint_pin_sync[1:0], breakpoint_pin};
    s_d.pin_req     = agreed(s_q.pin_sync, s_q.pin_req);
    s_d.clock_source_select_pin_lvl  = agreed(s_q.clock_source_select_pin_sync, s_q.clock_source_select_pin_lvl);
    s_d.breakpoint_pin_lvl    = agreed(s_q.breakpoint_pin_sync, s_q.breakpoint_pin_lvl);
    // Count clocks the synchronized breakpoint has been low
    if (s_q.breakpoint_pin_lvl) begin
      s_d.breakpoint_pin_low_cnt = 2'h0;
    end else if (s_q.breakpoint_pin_low_cnt != BREAKPOINT_PIN_LOW_CNT) begin
      s_d.breakpoint_pin_low_cnt = s_q.breakpoint_pin_low_cnt + 2'h1;
    end

    async_src    = power_up_reset | watchdog_timeout | internal_halt;
    sync_clk_src = s_q.pin_req | clock_reference_lost;
    sync_src     = sync_clk_src | test_mode_reset;

    // Bus monitor always runs while a synchronous reset is pending
    if (sync_src && bus_cycle_active && !s_q.sync_hold) begin
      s_d.mon_cnt = s_q.mon_cnt + 7'h01;
    end else begin
      s_d.mon_cnt = 7'h00;
    end
    s_d.mon_abort = sync_src && !s_q.sync_hold && bus_cycle_active &&
                    (s_q.mon_cnt == MON_TIMEOUT_CNT - 7'h01);
    // Waiting for cycle end lets an internal write finish intact
    cycle_end = !bus_cycle_active || bus_cycle_done || s_q.mon_abort;

    if (async_src) begin
      s_d.async_hold = 1'b1;
    end
    if (sync_src && cycle_end) begin
      s_d.sync_hold = 1'b1;
    end
    if (async_src || (sync_clk_src && cycle_end)) begin
      s_d.clk_rst_hold = 1'b1;
    end

    s_d.first_cycle_go = 1'b0;
    case (s_q.seq)
      ST_RESET: begin
        s_d.pin_reset_drive    = 1'b1;
        s_d.global_logic_reset = 1'b1;
        // A source arriving mid-sequence must still reach the clock unit
        s_d.clock_unit_reset   = s_q.clk_rst_hold | async_src |
                                 (sync_clk_src && cycle_end);
        s_d.boot_chip_select   = 1'b0;
        if (s_q.hold_cnt != RST_HOLD_CNT) begin
          s_d.hold_cnt = s_q.hold_cnt + 5'h01;
        end
        if (!async_src && !sync_src && s_q.hold_cnt == RST_HOLD_CNT) begin
          // Latch modes on the negation edge
          s_d.cfg.boot_16bit          = data_bus_in[BOOT_SIZE_BIT];
          s_d.cfg.cs_to_arbitration   = ~data_bus_in[ARB_BIT];
          s_d.cfg.cs_to_function_code = ~data_bus_in[FC_BIT];
          s_d.cfg.cs_to_address[4] = ~data_bus_in[ADDR_HI_BIT];
          for (int i = ADDR_HI_BIT - 1; i >= ADDR_LO_BIT; i--) begin
            s_d.cfg.cs_to_address[i-ADDR_LO_BIT] =
              ~data_bus_in[i] | s_d.cfg.cs_to_address[i-ADDR_LO_BIT+1];
          end
          s_d.cfg.general_port_e      = ~data_bus_in[PORT_E_BIT];
          s_d.cfg.general_port_f      = ~data_bus_in[PORT_F_BIT];
          s_d.cfg.reserved_mode       = ~data_bus_in[RSVD_BIT];
          s_d.cfg.clock_from_synthesizer_oscillator = s_q.clock_source_select_pin_lvl;
          s_d.cfg.background_enable   =
            (s_q.breakpoint_pin_low_cnt == BREAKPOINT_PIN_LOW_CNT);
          s_d.pin_reset_drive    = 1'b0;
          s_d.global_logic_reset = 1'b0;
          s_d.clock_unit_reset   = 1'b0;
          s_d.boot_chip_select   = 1'b1;
          s_d.async_hold   = 1'b0;
          s_d.sync_hold    = 1'b0;
          s_d.clk_rst_hold = 1'b0;
          s_d.first_cnt    = 4'h0;
          s_d.seq          = ST_RELEASE;
        end
      end
      ST_RELEASE: begin
        s_d.first_cnt = s_q.first_cnt + 4'h1;
        if (s_q.first_cnt == FIRST_CYCLE_CNT - 4'h1) begin
          s_d.first_cycle_go = 1'b1;
          s_d.seq            = ST_RUN;
        end
      end
      ST_RUN: begin
      end
      default: s_d.seq = ST_RESET;
    endcase

    // A new reset restarts the sequence from either released state
    if (s_q.seq != ST_RESET && (async_src || (sync_src && cycle_end))) begin
      s_d.seq                = ST_RESET;
      s_d.hold_cnt           = 5'h00;
      s_d.pin_reset_drive    = 1'b1;
      s_d.global_logic_reset = 1'b1;
      s_d.clock_unit_reset   = async_src | sync_clk_src;
      s_d.boot_chip_select   = 1'b0;
      s_d.first_cycle_go     = 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= STATE_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign pin_reset_drive       = s_q.pin_reset_drive;
  assign clock_unit_reset      = s_q.clock_unit_reset;
  assign global_logic_reset    = s_q.global_logic_reset;
  assign bus_monitor_abort     = s_q.mon_abort;
  assign first_bus_cycle_start = s_q.first_cycle_go;
  assign boot_chip_select      = s_q.boot_chip_select;
  assign mode_cfg              = s_q.cfg;

  // A new reset inside the count legally cancels the start
  property p_first_cycle;
    @(posedge sys_clk) disable iff (!rst_n || global_logic_reset)
    $fell(global_logic_reset) |-> ##10 first_bus_cycle_start;
  endproperty
  a_first_cycle: assert property (p_first_cycle)
    else $error("first bus cycle not ten clocks after release");

  property p_three_resets;
    @(posedge sys_clk) disable iff (!rst_n)
    global_logic_reset == pin_reset_drive;
  endproperty
  a_three_resets: assert property (p_three_resets)
    else $error("master and pin resets disagree");

  property p_async;
    @(posedge sys_clk) disable iff (!rst_n)
    watchdog_timeout |=> global_logic_reset && clock_unit_reset;
  endproperty
  a_async: assert property (p_async)
    else $error("asynchronous reset not immediate");

  property p_wait_cycle;
    @(posedge sys_clk) disable iff (!rst_n)
    (!global_logic_reset && sync_src && bus_cycle_active &&
     !bus_cycle_done && !bus_monitor_abort && !async_src) |=>
      !global_logic_reset;
  endproperty
  a_wait_cycle: assert property (p_wait_cycle)
    else $error("synchronous reset cut a bus cycle");

  property p_test_spares_clock;
    @(posedge sys_clk) disable iff (!rst_n)
    (!global_logic_reset && test_mode_reset && !async_src &&
     !sync_clk_src && !bus_cycle_active) |=>
      global_logic_reset && !clock_unit_reset;
  endproperty
  a_test_spares_clock: assert property (p_test_spares_clock)
    else $error("test reset drove clock unit reset");

  property p_monitor;
    @(posedge sys_clk) disable iff (!rst_n)
    bus_monitor_abort |=> global_logic_reset;
  endproperty
  a_monitor: assert property (p_monitor)
    else $error("monitor abort did not start reset");

  property p_boot_cs;
    @(posedge sys_clk) disable iff (!rst_n)
    $fell(global_logic_reset) |-> boot_chip_select;
  endproperty
  a_boot_cs: assert property (p_boot_cs)
    else $error("boot chip select not active at release");

  property p_cfg_hold;
    @(posedge sys_clk) disable iff (!rst_n)
    (!global_logic_reset && !$rose(global_logic_reset)) |=>
      ($stable(mode_cfg) || $fell(global_logic_reset));
  endproperty
  a_cfg_hold: assert property (p_cfg_hold)
    else $error("mode configuration changed outside reset");

  property p_addr_chain;
    @(posedge sys_clk) disable iff (!rst_n)
    mode_cfg.cs_to_address[4] |-> &mode_cfg.cs_to_address;
  endproperty
  a_addr_chain: assert property (p_addr_chain)
    else $error("address conversion chain broken");

  property p_abort_pulse;
    @(posedge sys_clk) disable iff (!rst_n)
    bus_monitor_abort |=> !bus_monitor_abort;
  endproperty
  a_abort_pulse: assert property (p_abort_pulse)
    else $error("monitor abort longer than one cycle");

  property p_abort_sync;
    @(posedge sys_clk) disable iff (!rst_n)
    bus_monitor_abort |-> $past(sync_src);
  endproperty
  a_abort_sync: assert property (p_abort_sync)
    else $error("monitor abort without synchronous source");

  property p_start_pulse;
    @(posedge sys_clk) disable iff (!rst_n)
    first_bus_cycle_start |=> !first_bus_cycle_start;
  endproperty
  a_start_pulse: assert property (p_start_pulse)
    else $error("first cycle start longer than one cycle");

  property p_start_not_in_reset;
    @(posedge sys_clk) disable iff (!rst_n)
    global_logic_reset |-> !first_bus_cycle_start;
  endproperty
  a_start_not_in_reset: assert property (p_start_not_in_reset)
    else $error("first cycle start during reset");

  property p_boot_off_in_reset;
    @(posedge sys_clk) disable iff (!rst_n)
    global_logic_reset |-> !boot_chip_select;
  endproperty
  a_boot_off_in_reset: assert property (p_boot_off_in_reset)
    else $error("boot chip select active during reset");

  property p_async_all;
    @(posedge sys_clk) disable iff (!rst_n)
    async_src |=> global_logic_reset && clock_unit_reset && pin_reset_drive;
  endproperty
  a_async_all: assert property (p_async_all)
    else $error("asynchronous source missed a reset output");

  property p_clock_lost;
    @(posedge sys_clk) disable iff (!rst_n)
    (!global_logic_reset && clock_reference_lost &&
     (!bus_cycle_active || bus_cycle_done)) |=>
      global_logic_reset && clock_unit_reset;
  endproperty
  a_clock_lost: assert property (p_clock_lost)
    else $error("clock loss did not reset the clock unit");

  property p_hold_min;
    @(posedge sys_clk) disable iff (!rst_n)
    $rose(global_logic_reset) |-> global_logic_reset[*8];
  endproperty
  a_hold_min: assert property (p_hold_min)
    else $error("reset released too early");

  property p_release_together;
    @(posedge sys_clk) disable iff (!rst_n)
    $fell(global_logic_reset) |-> !pin_reset_drive && !clock_unit_reset;
  endproperty
  a_release_together: assert property (p_release_together)
    else $error("reset outputs did not negate together");

  // Background mode needs two synchronized low clocks before release
  property p_breakpoint_pin_low;
    @(posedge sys_clk) disable iff (!rst_n)
    ($fell(global_logic_reset) && mode_cfg.background_enable) |->
      (!$past(s_q.breakpoint_pin_lvl, 2) && !$past(s_q.breakpoint_pin_lvl, 3));
  endproperty
  a_breakpoint_pin_low: assert property (p_breakpoint_pin_low)
    else $error("background mode enabled without two low clocks");

endmodule // reset_control_mode_latch

// ==== bench/mode_config_driver.sv ====
// Far-side model: external reset switch and data bus mode drivers
`timescale 1ns/100ps
module mode_config_driver
  import reset_mode_pkg::*;
#(
  parameter int DW = DATA_W
) (
  input  wire logic          pin_reset_drive,
  input  wire logic          ext_reset_req,
  input  wire logic [DW-1:0] low_pattern,
  output logic               reset_pin_n,
  output logic [DW-1:0]      data_bus_in
);
  logic [DW-1:0] drive_val;

  assign reset_pin_n = ~ext_reset_req;
  // Data line 11 is never pulled low, so the reserved mode is not entered
  always_comb begin
    drive_val = low_pattern;
    drive_val[RSVD_BIT] = 1'b1;
  end
  // Drivers act only while reset is driven; released lines float to the
  // weak pull-up level, so the sampled value is all ones
  assign data_bus_in = pin_reset_drive ? drive_val : '1;
endmodule // mode_config_driver

// ==== bench/tb_reset_control_mode_latch.sv ====
// Testbench: reset sources, release timing and reset-time mode latch
`timescale 1ns/100ps
module tb_reset_control_mode_latch;
  import reset_mode_pkg::*;

  logic            sys_clk, rstn, reset_pin_n, ext_req;
  logic            power_up_reset, watchdog_timeout, internal_halt;
  logic            clock_reference_lost, test_mode_reset;
  logic            bus_cycle_active, bus_cycle_done;
  logic [15:0]     data_bus_in, pattern;
  logic            clock_source_select_pin, breakpoint_pin;
  logic            pin_reset_drive, clock_unit_reset, global_logic_reset;
  logic            bus_monitor_abort, first_bus_cycle_start, boot_chip_select;
  mode_cfg_s       mode_cfg;
  int              failures, samples_checked, n;

  reset_control_mode_latch #(.DW(16)) reset_control_mode_latch_i (
    .sys_clk(sys_clk), .rstn(rstn), .reset_pin_n(reset_pin_n),
    .power_up_reset(power_up_reset), .watchdog_timeout(watchdog_timeout),
    .internal_halt(internal_halt),
    .clock_reference_lost(clock_reference_lost),
    .test_mode_reset(test_mode_reset), .bus_cycle_active(bus_cycle_active),
    .bus_cycle_done(bus_cycle_done), .data_bus_in(data_bus_in),
    .clock_source_select_pin(clock_source_select_pin),
    .breakpoint_pin(breakpoint_pin), .pin_reset_drive(pin_reset_drive),
    .clock_unit_reset(clock_unit_reset),
    .global_logic_reset(global_logic_reset),
    .bus_monitor_abort(bus_monitor_abort),
    .first_bus_cycle_start(first_bus_cycle_start),
    .boot_chip_select(boot_chip_select), .mode_cfg(mode_cfg));
  mode_config_driver #(.DW(16)) mode_config_driver_i (
    .pin_reset_drive(pin_reset_drive), .ext_reset_req(ext_req),
    .low_pattern(pattern), .reset_pin_n(reset_pin_n),
    .data_bus_in(data_bus_in));

  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  task automatic results();
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic check_bit(input logic got, input logic exp, input string m);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %0t %s", $time, m);
    end
  endtask

  task automatic check_cfg(input mode_cfg_s got, input mode_cfg_s exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %0t cfg %h exp %h", $time, got, exp);
    end
  endtask

  task automatic check_int(input int got, input int exp, input string m);
    samples_checked++;
    if (got != exp) begin
      failures++;
      $display("MISMATCH %0t %s %0d exp %0d", $time, m, got, exp);
    end
  endtask

  // Bounded wait; sel 0 reset high, 1 reset low, 2 abort, 3 first cycle
  task automatic wait_for(input int sel, input int lim, output int cnt);
    logic hit;
    cnt = 0;
    do begin
      @(negedge sys_clk);
      cnt++;
      case (sel)
        0: hit = global_logic_reset === 1'b1;
        1: hit = global_logic_reset === 1'b0;
        2: hit = bus_monitor_abort === 1'b1;
        default: hit = first_bus_cycle_start === 1'b1;
      endcase
    end while (!hit && cnt < lim);
    if (!hit) begin
      failures++;
      $display("MISMATCH %0t wait %0d ran out", $time, sel);
      results();
    end
  endtask

  // Expected latch contents from the sampled line levels
  function automatic mode_cfg_s exp_cfg(input logic [15:0] d,
                                        input logic ck, input logic bp);
    mode_cfg_s c;
    c.boot_16bit = d[0];
    c.cs_to_arbitration = ~d[1];
    c.cs_to_function_code = ~d[2];
    c.cs_to_address = 5'h00;
    for (int k = 0; k < 5; k++) begin
      for (int j = k + 3; j < 8; j++) begin
        if (!d[j]) c.cs_to_address[k] = 1'b1;
      end
    end
    c.general_port_e = ~d[8];
    c.general_port_f = ~d[9];
    c.reserved_mode = ~d[11];
    c.clock_from_synthesizer_oscillator = ck;
    c.background_enable = ~bp;
    return c;
  endfunction

  // Release, latch and first bus cycle after every reset
  task automatic release_check(input mode_cfg_s exp);
    wait_for(1, 200, n);
    check_cfg(mode_cfg, exp);
    check_bit(boot_chip_select, 1'b1, "boot select");
    check_bit(clock_unit_reset, 1'b0, "clock reset");
    wait_for(3, 30, n);
    // Counted from the negedge that first shows the release
    check_int(n, FIRST_CYCLE_DLY, "first cycle");
  endtask

  initial begin
    {rstn, ext_req, power_up_reset, watchdog_timeout, internal_halt} = '0;
    {clock_reference_lost, test_mode_reset, bus_cycle_active} = '0;
    {bus_cycle_done, clock_source_select_pin, breakpoint_pin} = '0;
    pattern = 16'hfedc;
    repeat (2) @(negedge sys_clk);
    check_cfg(mode_cfg, MODE_CFG_RST);
    check_bit(global_logic_reset, 1'b1, "reset held");
    rstn = 1'b1;
    release_check(exp_cfg(16'hfedc, 1'b0, 1'b0));
    $display("test power-up done");
    // Test source spares the clock unit; drivers released lines now
    {clock_source_select_pin, breakpoint_pin} = 2'b11;
    pattern = 16'hffff;
    test_mode_reset = 1'b1;
    @(negedge sys_clk);
    test_mode_reset = 1'b0;
    check_bit(pin_reset_drive, 1'b1, "pin drive");
    check_bit(global_logic_reset, 1'b1, "global");
    check_bit(clock_unit_reset, 1'b0, "test clock");
    release_check(MODE_CFG_RST);
    $display("test mode done");
    // Sync source waits for bus cycle end
    bus_cycle_active = 1'b1;
    clock_reference_lost = 1'b1;
    repeat (5) @(negedge sys_clk);
    check_bit(global_logic_reset, 1'b0, "held off");
    bus_cycle_done = 1'b1;
    @(negedge sys_clk);
    {bus_cycle_done, bus_cycle_active, clock_reference_lost} = '0;
    wait_for(0, 3, n);
    check_bit(clock_unit_reset, 1'b1, "clock lost");
    release_check(MODE_CFG_RST);
    $display("test sync done");
    // Stuck cycle ended by the monitor
    bus_cycle_active = 1'b1;
    ext_req = 1'b1;
    wait_for(2, MON_TIMEOUT + 8, n);
    check_bit(global_logic_reset, 1'b0, "before abort");
    bus_cycle_active = 1'b0;
    ext_req = 1'b0;
    wait_for(0, 3, n);
    release_check(MODE_CFG_RST);
    $display("test monitor done");
    // Asynchronous sources act mid-cycle
    for (int s = 0; s < 3; s++) begin
      bus_cycle_active = 1'b1;
      {power_up_reset, watchdog_timeout, internal_halt} = 3'(4 >> s);
      @(negedge sys_clk);
      {power_up_reset, watchdog_timeout, internal_halt} = '0;
      check_bit(global_logic_reset, 1'b1, "async");
      check_bit(clock_unit_reset, 1'b1, "async clock");
      bus_cycle_active = 1'b0;
      release_check(MODE_CFG_RST);
    end
    $display("test async done");
    results();
  end
endmodule // tb_reset_control_mode_latch
